/* File: design/rtcac_defs.vh */
/*
  register offsets, field layouts, bit positions and response codes of the
  rtc alarm compare block. assumes inclusion by bare name.
*/
`ifndef RTCAC_DEFS_VH
`define RTCAC_DEFS_VH

`define RTCAC_ADDR_W 6
`define RTCAC_OFF_SECOND_ALARM 6'h00
`define RTCAC_OFF_MINUTE_ALARM 6'h04
`define RTCAC_OFF_HOUR_ALARM 6'h08
`define RTCAC_OFF_WEEKDAY_ALARM 6'h0C
`define RTCAC_OFF_DATE_ALARM 6'h10
`define RTCAC_OFF_MONTH_ALARM 6'h14
`define RTCAC_OFF_CONTROL 6'h18
`define RTCAC_OFF_IRQ_STATUS 6'h1C
`define RTCAC_OFF_IRQ_ENABLE 6'h20
`define RTCAC_OFF_IRQ_CLEAR 6'h24

`define RTCAC_ENB_BIT 7
`define RTCAC_MASK_SECOND 8'h7F
`define RTCAC_MASK_MINUTE 8'h7F
`define RTCAC_MASK_HOUR 8'h3F
`define RTCAC_MASK_WEEKDAY 8'h07
`define RTCAC_MASK_DATE 8'h3F
`define RTCAC_MASK_MONTH 8'h1F

`define RTCAC_CTRL_AF_BIT 0
`define RTCAC_CTRL_AIE_BIT 3
`define RTCAC_CTRL_MASK 8'h09
`define RTCAC_IRQ_ALARM_BIT 0
`define RTCAC_IRQ_MASK 8'h01

`define RTCAC_RESP_OKAY 2'h0
`define RTCAC_RESP_SLVERR 2'h2

`endif

/* File: design/rtcac_field_cmp.v */
/*
  one alarm field comparator: masks value bits, compares with counter,
  passes when its enable is clear. assumes counter is synchronous to aclk.
*/
`timescale 1ns/10ps
module rtcac_field_cmp #(
  parameter [7:0] VALUE_MASK = 8'h7F
) (
  input wire [7:0] alarm_value,
  input wire [7:0] counter_value,
  output wire field_ok
);
  wire enabled;
  assign enabled = alarm_value[7];
  // disabled fields always agree
  assign field_ok = !enabled ||
    ((alarm_value & VALUE_MASK) == (counter_value & VALUE_MASK));
endmodule // rtcac_field_cmp

/* File: design/rtcac_axil_slave.v */
/*
  axi4-lite slave front end: accepts one write and one read at a time,
  address and data in either order, and gives a one-cycle register strobe.
  assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
module rtcac_axil_slave #(
  parameter AW = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_stb,
  output wire [AW-1:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  input wire [1:0] wr_resp,
  output wire rd_stb,
  output wire [AW-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire [1:0] rd_resp
);
  reg aw_full_reg;
  reg w_full_reg;
  reg [AW-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_stb = aw_full_reg && w_full_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;
  assign rd_stb = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {AW{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_stb) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_stb) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_data;
        rresp_reg <= rd_resp;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
endmodule // rtcac_axil_slave

/* File: design/rtcac_top.v */
/*
  rtc alarm compare: six bcd alarm registers with per-field enables, the
  alarm flag, its interrupt enable and an interrupt status/enable/clear set,
  all behind axi4-lite. assumes calendar counters arrive synchronous to aclk
  and that a power-on reset is marked by por_flag during aresetn low.
*/
`timescale 1ns/10ps
`include "rtcac_defs.vh"
module rtcac_top (
  input wire aclk,
  input wire aresetn,
  input wire por_flag,
  input wire [`RTCAC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`RTCAC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] second_counter,
  input wire [7:0] minute_counter,
  input wire [7:0] hour_counter,
  input wire [7:0] weekday_counter,
  input wire [7:0] date_counter,
  input wire [7:0] month_counter,
  output wire alarm_flag,
  output wire alarm_irq,
  output wire irq
);
  localparam NF = 6;

  wire wr_stb;
  wire [`RTCAC_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_stb;
  wire [`RTCAC_ADDR_W-1:0] rd_addr;
  reg [31:0] rd_data;
  reg [1:0] rd_resp;
  reg [1:0] wr_resp;

  reg [NF-1:0] field_compare_enable_reg;
  reg [6:0] alarm_value_reg [0:NF-1];
  reg alarm_flag_reg;
  reg alarm_interrupt_enable_reg;
  reg irq_status_reg;
  reg irq_enable_reg;
  reg [47:0] counters_last_reg;
  reg match_last_reg;

  wire [47:0] counters_now;
  wire [NF-1:0] field_ok;
  wire all_match;
  wire counters_changed;
  wire alarm_event;
  wire wr_lane0;
  wire ctrl_write;
  wire clr_write;

  assign counters_now = {month_counter, date_counter, weekday_counter,
    hour_counter, minute_counter, second_counter};
  assign wr_lane0 = wr_stb && wr_strb[0];

  rtcac_axil_slave #(
    .AW(`RTCAC_ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_resp(wr_resp),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_resp(rd_resp)
  );

  // field masks per alarm register
  function [7:0] field_mask;
    input integer idx;
    begin
      case (idx)
        0: field_mask = `RTCAC_MASK_SECOND;
        1: field_mask = `RTCAC_MASK_MINUTE;
        2: field_mask = `RTCAC_MASK_HOUR;
        3: field_mask = `RTCAC_MASK_WEEKDAY;
        4: field_mask = `RTCAC_MASK_DATE;
        default: field_mask = `RTCAC_MASK_MONTH;
      endcase
    end
  endfunction

  function [`RTCAC_ADDR_W-1:0] field_offset;
    input integer idx;
    begin
      case (idx)
        0: field_offset = `RTCAC_OFF_SECOND_ALARM;
        1: field_offset = `RTCAC_OFF_MINUTE_ALARM;
        2: field_offset = `RTCAC_OFF_HOUR_ALARM;
        3: field_offset = `RTCAC_OFF_WEEKDAY_ALARM;
        4: field_offset = `RTCAC_OFF_DATE_ALARM;
        default: field_offset = `RTCAC_OFF_MONTH_ALARM;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi = gi + 1) begin : g_field
      wire [7:0] mask;
      wire hit;
      assign mask = field_mask(gi);
      assign hit = wr_lane0 && (wr_addr == field_offset(gi));
      // value bits have no reset at all
      always @(posedge aclk) begin
        if (hit) begin
          alarm_value_reg[gi] <= wr_data[6:0] & mask[6:0];
        end
      end
      always @(posedge aclk) begin
        if (!aresetn && por_flag) begin
          field_compare_enable_reg[gi] <= 1'b0;
        end else if (aresetn && hit) begin
          field_compare_enable_reg[gi] <= wr_data[`RTCAC_ENB_BIT];
        end
      end
      rtcac_field_cmp #(
        .VALUE_MASK(mask_const(gi))
      ) u_cmp (
        .alarm_value({field_compare_enable_reg[gi], alarm_value_reg[gi]}),
        .counter_value(counters_now[gi*8 +: 8]),
        .field_ok(field_ok[gi])
      );
    end
  endgenerate

  function [7:0] mask_const;
    input integer idx;
    begin
      mask_const = field_mask(idx);
    end
  endfunction

  assign all_match = &field_ok;
  assign counters_changed = counters_now != counters_last_reg;
  // set when a match first appears and on each counter step while it holds
  assign alarm_event = all_match && (counters_changed || !match_last_reg);
  assign ctrl_write = wr_lane0 && (wr_addr == `RTCAC_OFF_CONTROL);
  assign clr_write = wr_lane0 && (wr_addr == `RTCAC_OFF_IRQ_CLEAR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      // track the counters through reset so release brings no false match step
      counters_last_reg <= counters_now;
      match_last_reg <= 1'b1;
      alarm_flag_reg <= 1'b0;
      alarm_interrupt_enable_reg <= 1'b0;
      irq_status_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
    end else begin
      counters_last_reg <= counters_now;
      match_last_reg <= all_match;
      if (ctrl_write) begin
        alarm_interrupt_enable_reg <= wr_data[`RTCAC_CTRL_AIE_BIT];
      end
      // set wins over a clear in the same cycle
      if (alarm_event) begin
        alarm_flag_reg <= 1'b1;
      end else if (ctrl_write && !wr_data[`RTCAC_CTRL_AF_BIT]) begin
        alarm_flag_reg <= 1'b0;
      end
      if (alarm_event) begin
        irq_status_reg <= 1'b1;
      end else if (clr_write && wr_data[`RTCAC_IRQ_ALARM_BIT]) begin
        irq_status_reg <= 1'b0;
      end
      if (wr_lane0 && (wr_addr == `RTCAC_OFF_IRQ_ENABLE)) begin
        irq_enable_reg <= wr_data[`RTCAC_IRQ_ALARM_BIT];
      end
    end
  end

  assign alarm_flag = alarm_flag_reg;
  assign alarm_irq = alarm_flag_reg && alarm_interrupt_enable_reg;
  assign irq = irq_status_reg && irq_enable_reg;

  // read mux and responses
  always @* begin
    rd_data = 32'h00000000;
    rd_resp = `RTCAC_RESP_OKAY;
    case (rd_addr)
      `RTCAC_OFF_SECOND_ALARM: rd_data[7:0] = {field_compare_enable_reg[0], alarm_value_reg[0]};
      `RTCAC_OFF_MINUTE_ALARM: rd_data[7:0] = {field_compare_enable_reg[1], alarm_value_reg[1]};
      `RTCAC_OFF_HOUR_ALARM: rd_data[7:0] = {field_compare_enable_reg[2], alarm_value_reg[2]};
      `RTCAC_OFF_WEEKDAY_ALARM: rd_data[7:0] = {field_compare_enable_reg[3], alarm_value_reg[3]};
      `RTCAC_OFF_DATE_ALARM: rd_data[7:0] = {field_compare_enable_reg[4], alarm_value_reg[4]};
      `RTCAC_OFF_MONTH_ALARM: rd_data[7:0] = {field_compare_enable_reg[5], alarm_value_reg[5]};
      `RTCAC_OFF_CONTROL: begin
        rd_data[`RTCAC_CTRL_AIE_BIT] = alarm_interrupt_enable_reg;
        rd_data[`RTCAC_CTRL_AF_BIT] = alarm_flag_reg;
      end
      `RTCAC_OFF_IRQ_STATUS: rd_data[`RTCAC_IRQ_ALARM_BIT] = irq_status_reg;
      `RTCAC_OFF_IRQ_ENABLE: rd_data[`RTCAC_IRQ_ALARM_BIT] = irq_enable_reg;
      `RTCAC_OFF_IRQ_CLEAR: rd_data = 32'h00000000;
      default: rd_resp = `RTCAC_RESP_SLVERR;
    endcase
  end

  always @* begin
    case (wr_addr)
      `RTCAC_OFF_SECOND_ALARM,
      `RTCAC_OFF_MINUTE_ALARM,
      `RTCAC_OFF_HOUR_ALARM,
      `RTCAC_OFF_WEEKDAY_ALARM,
      `RTCAC_OFF_DATE_ALARM,
      `RTCAC_OFF_MONTH_ALARM,
      `RTCAC_OFF_CONTROL,
      `RTCAC_OFF_IRQ_ENABLE,
      `RTCAC_OFF_IRQ_CLEAR: wr_resp = `RTCAC_RESP_OKAY;
      default: wr_resp = `RTCAC_RESP_SLVERR;
    endcase
  end
endmodule // rtcac_top

/* File: verif/rtcac_checker.sv */
/*
  checker for rtcac_top: bus response timing, read data width, alarm flag
  and alarm interrupt relations. assumes one clock and sync active-low reset.
*/
`timescale 1ns/10ps
module rtcac_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire alarm_flag,
  input wire alarm_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
  property p_rd_resp; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("bvalid kept after handshake");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("rvalid kept after handshake");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while busy");
  property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_flag_fall; $fell(alarm_flag) |-> s_axi_bvalid;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without write");
  property p_irq; alarm_irq |-> alarm_flag; endproperty
  a_irq: assert property (p_irq) else $error("alarm irq without flag");
endmodule // rtcac_checker
bind rtcac_top rtcac_checker u_chk (.*);

/* File: verif/rtc_alarm_compare_tb.sv */
/*
  self-checking bench for rtcac_top: registers over axi4-lite, matching,
  flag, interrupts, resets. assumes rtcac_defs.vh on the include path.
*/
`timescale 1ns/10ps
`include "rtcac_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module rtc_alarm_compare_tb;
  localparam logic [1:0] OK = `RTCAC_RESP_OKAY;
  localparam logic [1:0] ERR = `RTCAC_RESP_SLVERR;
  localparam logic [5:0] CTL = `RTCAC_OFF_CONTROL;
  localparam logic [5:0] IST = `RTCAC_OFF_IRQ_STATUS;
  localparam logic [5:0] IEN = `RTCAC_OFF_IRQ_ENABLE;
  localparam logic [5:0] ICL = `RTCAC_OFF_IRQ_CLEAR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_flag = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic alarm_flag;
  logic alarm_irq;
  logic irq;
  logic [7:0] cnt [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [7:0] msk [6] = '{`RTCAC_MASK_SECOND, `RTCAC_MASK_MINUTE, `RTCAC_MASK_HOUR,
    `RTCAC_MASK_WEEKDAY, `RTCAC_MASK_DATE, `RTCAC_MASK_MONTH};
  logic [7:0] tm [6] = '{8'h30, 8'h45, 8'h23, 8'h06, 8'h31, 8'h12};
  logic [31:0] rv;
  int fails = 0;
  int check_count = 0;

  rtcac_top uut (.second_counter(cnt[0]), .minute_counter(cnt[1]), .hour_counter(cnt[2]),
    .weekday_counter(cnt[3]), .date_counter(cnt[4]), .month_counter(cnt[5]), .*);

  initial forever #25 aclk = ~aclk;

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [1:0] er);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      `CHK(s_axi_rresp, er)
    end
  endtask

  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  task automatic do_reset(input logic por);
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      por_flag <= por;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      por_flag <= 1'b0;
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    por_flag <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(6'(4 * i), OK);
      `CHK(rv & 32'h00000080, 32'h00000000)
    end
    for (int i = 0; i < 6; i++) begin
      wr(6'(4 * i), 8'hFF, OK);
      rd(6'(4 * i), OK);
      `CHK(rv, {24'h000000, 8'h80 | msk[i]})
    end
    $display("test layout done");
    cnt[0] <= 8'h29;
    for (int i = 1; i < 6; i++) cnt[i] <= tm[i];
    for (int i = 0; i < 6; i++) wr(6'(4 * i), 8'h80 | tm[i], OK);
    wr(CTL, 8'h08, OK);
    wr(ICL, 8'h01, OK);
    wr(IEN, 8'h01, OK);
    settle;
    `CHK(alarm_flag, 1'b0)
    @(posedge aclk);
    cnt[0] <= tm[0];
    settle;
    `CHK(alarm_flag, 1'b1)
    `CHK(alarm_irq, 1'b1)
    `CHK(irq, 1'b1)
    rd(CTL, OK);
    `CHK(rv, 32'h00000009)
    wr(CTL, 8'h09, OK);
    `CHK(alarm_flag, 1'b1)
    wr(CTL, 8'h08, OK);
    `CHK(alarm_flag, 1'b0)
    `CHK(alarm_irq, 1'b0)
    wr(IEN, 8'h00, OK);
    `CHK(irq, 1'b0)
    rd(IST, OK);
    `CHK(rv, 32'h00000001)
    wr(ICL, 8'h01, OK);
    rd(IST, OK);
    `CHK(rv, 32'h00000000)
    $display("test flag done");
    wr(CTL, 8'h00, OK);
    wr(6'h08, 8'hA2, OK);
    wr(6'h00, tm[0], OK);
    @(posedge aclk);
    cnt[0] <= 8'h31;
    settle;
    `CHK(alarm_flag, 1'b0)
    @(posedge aclk);
    cnt[2] <= 8'h22;
    settle;
    `CHK(alarm_flag, 1'b1)
    `CHK(alarm_irq, 1'b0)
    $display("test enables done");
    wr(6'h28, 8'h01, ERR);
    rd(6'h3C, ERR);
    `CHK(rv, 32'h00000000)
    $display("test unmapped done");
    do_reset(1'b0);
    rd(6'h04, OK);
    `CHK(alarm_flag, 1'b0)
    `CHK(rv, 32'h000000C5)
    do_reset(1'b1);
    rd(6'h04, OK);
    `CHK(rv, 32'h00000045)
    $display("test resets done");
    report_and_stop;
  end
endmodule // rtc_alarm_compare_tb
